/* verilog/sram_port_pkg.sv */
// Shared constants, carriers and helpers for the flow-through SRAM port.
// Assumes one clock domain; every consumer refers to names as sram_port_pkg::name.
package sram_port_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Geometry
    localparam int ADDR_W = 19;
    localparam int LANE_W = 9;
    localparam int LANES = 2;
    localparam int BURST_W = 2;
    localparam int BASE_W = ADDR_W - BURST_W;
    localparam int DEPTH = 524288;
    localparam int SYNC_W = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions of the asynchronous pin synchroniser
    localparam int SYNC_OE_BIT = 0;
    localparam int SYNC_MODE_BIT = 1;
    localparam int SYNC_SLEEP_BIT = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Reset and encoded values
    localparam logic [SYNC_W-1:0] SYNC_RST = 3'h3;
    localparam logic [1:0] NO_LANES = 2'h0;
    localparam logic [1:0] ALL_LANES = 2'h3;
    localparam logic [1:0] BUF_EMPTY = 2'h0;
    localparam logic [1:0] BUF_FULL = 2'h2;
    localparam logic [1:0] BEAT_ONE = 2'h1;
    localparam logic [1:0] BEAT_ZERO = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [LANE_W-1:0] byte_lane_1;
        logic [LANE_W-1:0] byte_lane_0;
    } word_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] lane_we;
        word_t data;
    } wr_entry_t;

    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_READ,
        ACC_WRITE
    } acc_t;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    // Burst sequence: interleaved xors the beat in, linear adds modulo four
    function automatic logic [BURST_W-1:0] burst_offset(logic [BURST_W-1:0] start,
                                                        logic [BURST_W-1:0] beat,
                                                        logic interleaved);
        if (interleaved) begin
            return start ^ beat;
        end
        return BURST_W'(start + beat);
    endfunction

    // Replace the lanes selected by we with the newer word
    function automatic word_t lane_merge(word_t base, word_t upd, logic [LANES-1:0] we);
        word_t r;
        r = base;
        if (we[0]) begin
            r.byte_lane_0 = upd.byte_lane_0;
        end
        if (we[1]) begin
            r.byte_lane_1 = upd.byte_lane_1;
        end
        return r;
    endfunction

endpackage

/* verilog/sram_array.sv */
// Storage array of the port: one write port with per-lane enables, one read port.
// Assumes the caller resolves read-after-write hazards; a read on the written
// address in the same edge returns the old contents.
`timescale 1ns/1ps
module sram_array (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic we,
    input wire logic [1:0] lane_we,
    input wire logic [18:0] waddr,
    input sram_port_pkg::word_t wdata,
    input wire logic re,
    input wire logic [18:0] raddr,
    output sram_port_pkg::word_t rdata_r
);

    logic [sram_port_pkg::LANE_W-1:0] lane0_mem [0:sram_port_pkg::DEPTH-1];
    logic [sram_port_pkg::LANE_W-1:0] lane1_mem [0:sram_port_pkg::DEPTH-1];

    ////////////////////////////////////////////////////////////////////////////
    // Byte-lane writes, each lane on its own enable
    always_ff @(posedge clk) begin
        if (we && lane_we[0]) begin
            lane0_mem[waddr] <= wdata.byte_lane_0;
        end
        if (we && lane_we[1]) begin
            lane1_mem[waddr] <= wdata.byte_lane_1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered read; holds when not enabled so a stalled edge changes nothing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else if (re) begin
            rdata_r.byte_lane_0 <= lane0_mem[raddr];
            rdata_r.byte_lane_1 <= lane1_mem[raddr];
        end
    end

endmodule

/* verilog/sync_flowthru_sram_port.sv */
// Synchronous port logic of a 512K x 18 flow-through SRAM with a 2-bit burst counter.
// Assumes the controller runs on clk; output enable, sleep and burst mode are
// asynchronous pins and the bench resolves the data wires from data_oe.
`timescale 1ns/1ps
module sync_flowthru_sram_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [18:0] addr,
    input wire logic read_not_write,
    input wire logic chip_sel_a_n,
    input wire logic chip_sel_mid,
    input wire logic chip_sel_b_n,
    input wire logic advance_or_load_n,
    input wire logic clock_gate_n,
    input wire logic [1:0] lane_write_en_n,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic burst_mode_sel,
    input sram_port_pkg::word_t data_in,
    output sram_port_pkg::word_t data_out,
    output logic [1:0] data_oe,
    output logic sleep_active
);

    logic [sram_port_pkg::SYNC_W-1:0] async_meta_r;
    logic [sram_port_pkg::SYNC_W-1:0] async_sync_r;
    logic oe_n_s;
    logic mode_s;
    logic sleep_s;

    sram_port_pkg::acc_t state_r;
    logic [sram_port_pkg::BASE_W-1:0] base_r;
    logic [1:0] start_r;
    logic [1:0] beat_r;
    logic [1:0] next_beat;
    logic [18:0] xfer_addr_r;
    logic rd_pend_r;
    logic wr_pend_r;
    logic [1:0] lanes_r;

    logic sel;
    logic run;
    logic load;
    logic desel;
    logic adv;
    logic access;
    logic acc_read;
    logic [18:0] acc_addr;

    sram_port_pkg::wr_entry_t buf_r [0:1];
    logic wptr_r;
    logic rptr_r;
    logic [1:0] cnt_r;
    logic buf_in_ready;
    logic buf_out_ready;
    logic push;
    logic pop;
    sram_port_pkg::wr_entry_t push_entry;
    sram_port_pkg::wr_entry_t head;

    logic [1:0] byp_mask_r;
    logic [1:0] byp_mask_nxt;
    sram_port_pkg::word_t byp_data_r;
    sram_port_pkg::word_t byp_data_nxt;
    sram_port_pkg::word_t rdata;
    logic idx;

    ////////////////////////////////////////////////////////////////////////////
    // Asynchronous pins pass two flops; only the second stage is ever read
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            async_meta_r <= sram_port_pkg::SYNC_RST;
            async_sync_r <= sram_port_pkg::SYNC_RST;
        end else begin
            async_meta_r <= {sleep_request, burst_mode_sel, output_enable_n};
            async_sync_r <= async_meta_r;
        end
    end

    assign oe_n_s = async_sync_r[sram_port_pkg::SYNC_OE_BIT];
    assign mode_s = async_sync_r[sram_port_pkg::SYNC_MODE_BIT];
    // Two-flop delay doubles as the two-cycle sleep entry and exit
    assign sleep_s = async_sync_r[sram_port_pkg::SYNC_SLEEP_BIT];
    assign sleep_active = sleep_s;

    ////////////////////////////////////////////////////////////////////////////
    // Cycle decode
    // The array drains every cycle outside sleep and sleep blocks pushes, so the full stall is only a guard
    assign sel = !chip_sel_a_n && chip_sel_mid && !chip_sel_b_n;
    assign run = !clock_gate_n && !sleep_s && buf_in_ready;
    assign load = run && !advance_or_load_n && sel;
    assign desel = run && !advance_or_load_n && !sel;
    assign adv = run && advance_or_load_n && (state_r != sram_port_pkg::ACC_IDLE);
    assign access = load || adv;
    assign next_beat = 2'(beat_r + sram_port_pkg::BEAT_ONE);

    // Read/write and address pins are only looked at on a load; a burst beat uses held state for both
    assign acc_read = load ? read_not_write : (state_r == sram_port_pkg::ACC_READ);
    assign acc_addr = load ? addr
                           : {base_r, sram_port_pkg::burst_offset(start_r, next_beat, mode_s)};

    ////////////////////////////////////////////////////////////////////////////
    // Access state: read, write or deselected
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= sram_port_pkg::ACC_IDLE;
        end else if (load) begin
            state_r <= read_not_write ? sram_port_pkg::ACC_READ : sram_port_pkg::ACC_WRITE;
        end else if (desel) begin
            state_r <= sram_port_pkg::ACC_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Burst counter: base and start taken on load, beat steps on advance
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            base_r <= '0;
            start_r <= sram_port_pkg::BEAT_ZERO;
            beat_r <= sram_port_pkg::BEAT_ZERO;
        end else if (load) begin
            base_r <= addr[18:2];
            start_r <= addr[1:0];
            beat_r <= sram_port_pkg::BEAT_ZERO;
        end else if (adv) begin
            beat_r <= next_beat;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data-phase control, one cycle behind the sampled control
    // Frozen edges keep the pending phase so it completes on the next live edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            xfer_addr_r <= '0;
            rd_pend_r <= 1'b0;
            wr_pend_r <= 1'b0;
            lanes_r <= sram_port_pkg::NO_LANES;
        end else if (run) begin
            rd_pend_r <= access && acc_read;
            wr_pend_r <= access && !acc_read;
            lanes_r <= (access && !acc_read) ? ~lane_write_en_n : sram_port_pkg::NO_LANES;
            if (access) begin
                xfer_addr_r <= acc_addr;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry write buffer between the data pins and the array
    // Write data is registered here, which is the input register of the lanes
    assign buf_in_ready = (cnt_r != sram_port_pkg::BUF_FULL);
    assign buf_out_ready = !sleep_s;
    assign push = run && wr_pend_r && (lanes_r != sram_port_pkg::NO_LANES);
    assign pop = (cnt_r != sram_port_pkg::BUF_EMPTY) && buf_out_ready;
    assign push_entry = '{addr: xfer_addr_r, lane_we: lanes_r, data: data_in};
    assign head = buf_r[rptr_r];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            buf_r[0] <= '0;
            buf_r[1] <= '0;
        end else if (push) begin
            buf_r[wptr_r] <= push_entry;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wptr_r <= 1'b0;
            rptr_r <= 1'b0;
            cnt_r <= sram_port_pkg::BUF_EMPTY;
        end else begin
            if (push) begin
                wptr_r <= !wptr_r;
            end
            if (pop) begin
                rptr_r <= !rptr_r;
            end
            case ({push, pop})
                2'b10: cnt_r <= 2'(cnt_r + 2'h1);
                2'b01: cnt_r <= 2'(cnt_r - 2'h1);
                default: cnt_r <= cnt_r;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read bypass: words still buffered or arriving now are newer than the array
    always_comb begin
        byp_mask_nxt = sram_port_pkg::NO_LANES;
        byp_data_nxt = '0;
        idx = 1'b0;
        for (int i = 0; i < 2; i++) begin
            idx = rptr_r ^ 1'(i);
            if ((2'(i) < cnt_r) && (buf_r[idx].addr == acc_addr)) begin
                byp_data_nxt = sram_port_pkg::lane_merge(byp_data_nxt, buf_r[idx].data, buf_r[idx].lane_we);
                byp_mask_nxt = byp_mask_nxt | buf_r[idx].lane_we;
            end
        end
        if (push && (push_entry.addr == acc_addr)) begin
            byp_data_nxt = sram_port_pkg::lane_merge(byp_data_nxt, push_entry.data, push_entry.lane_we);
            byp_mask_nxt = byp_mask_nxt | push_entry.lane_we;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            byp_mask_r <= sram_port_pkg::NO_LANES;
            byp_data_r <= '0;
        end else if (access && acc_read) begin
            byp_mask_r <= byp_mask_nxt;
            byp_data_r <= byp_data_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Array; the read is issued at the sampling edge so data shows next cycle
    sram_array u_array (
        .clk(clk),
        .rst_n(rst_n),
        .we(pop),
        .lane_we(head.lane_we),
        .waddr(head.addr),
        .wdata(head.data),
        .re(access && acc_read),
        .raddr(acc_addr),
        .rdata_r(rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output lanes: merge of two registers; drive only for a read with OE low
    // OE is seen two cycles late, a cost of synchronising the pin
    assign data_out = sram_port_pkg::lane_merge(rdata, byp_data_r, byp_mask_r);
    assign data_oe = {2{rd_pend_r && !oe_n_s && !sleep_s}};

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    deselect_hiz_a: assert property (desel |=> data_oe == sram_port_pkg::NO_LANES)
        else $error("lanes driven after deselect");

    read_data_phase_a: assert property ((load && read_not_write) |=> (rd_pend_r && !wr_pend_r))
        else $error("read data phase missing one cycle after load");

    write_lanes_a: assert property ((load && !read_not_write)
                                    |=> (wr_pend_r && lanes_r == ~$past(lane_write_en_n)))
        else $error("write lanes not taken from enables");

    read_lanes_a: assert property ((load && read_not_write) |=> lanes_r == sram_port_pkg::NO_LANES)
        else $error("read stored lane enables");

    gate_hold_a: assert property ((clock_gate_n && rst_n)
                                  |=> ($stable(state_r) && $stable(beat_r) && $stable(xfer_addr_r)
                                       && $stable(data_out)))
        else $error("state moved on a gated edge");

    burst_step_a: assert property (adv |=> beat_r == 2'($past(beat_r) + 2'h1))
        else $error("burst counter did not step");

    burst_order_a: assert property (adv |=> xfer_addr_r[1:0] == ($past(mode_s)
                                    ? ($past(start_r) ^ $past(next_beat))
                                    : 2'($past(start_r) + $past(next_beat))))
        else $error("burst order wrong");

    load_capture_a: assert property (load |=> (xfer_addr_r == $past(addr) && start_r == $past(addr[1:0])))
        else $error("load did not capture the address");

    burst_base_a: assert property (adv |=> xfer_addr_r[18:2] == $past(base_r))
        else $error("burst beat used the external address");

    sleep_freeze_a: assert property ((sleep_s && rst_n) |=> ($stable(state_r) && data_oe == 2'h0))
        else $error("port active in sleep");

    read_burst_c: cover property ((load && read_not_write) ##1 adv ##1 adv ##1 adv);
    write_then_read_c: cover property ((load && !read_not_write) ##1 (load && read_not_write));
    gated_read_c: cover property ((load && read_not_write) ##1 clock_gate_n ##1 !clock_gate_n);
    buffer_stream_c: cover property (push && pop);

endmodule

/* verif/ctrl_model.sv */
// Controller side of the data lanes: drives write words, otherwise a changing pattern.
// Assumes the bench says at each falling edge whether a write data beat is due.
`timescale 1ns/1ps
module ctrl_model (
    input wire logic clk,
    input wire logic drive_en,
    input wire logic [17:0] word,
    input wire logic [1:0] dev_oe,
    input sram_port_pkg::word_t dev_word,
    output sram_port_pkg::word_t lane_level
);
    logic [17:0] drive_r;

    ////////////////////////////////////////////////////////////////////////////
    // Write data one cycle after its control beat, held across frozen edges.
    // A released lane flips every cycle, so a stale word never passes for data.
    initial drive_r = 18'h0;
    always @(negedge clk) begin
        #1;
        if (drive_en) begin
            drive_r = word;
        end else begin
            drive_r = ~drive_r;
        end
    end

    // The device owns the wire while it drives; both lanes share one enable
    assign lane_level = (dev_oe != 2'h0) ? dev_word : drive_r;
endmodule

/* verif/tb_top.sv */
// Bench for the SRAM port: reference memory, burst model, random and corner traffic.
// Assumes ctrl_model resolves the lanes; pins change at the falling edge of clk.
`timescale 1ns/1ps
module tb_top;
    logic clk, rst_n, read_not_write, chip_sel_a_n, chip_sel_mid, chip_sel_b_n, advance_or_load_n;
    logic clock_gate_n, output_enable_n, sleep_request, burst_mode_sel, sleep_active, wr_go;
    logic [18:0] addr;
    logic [1:0] lane_write_en_n, data_oe, last_oe, exp_we, start, bt, op, exp_op;
    logic [17:0] wr_word, last_out;
    logic [16:0] base;
    sram_port_pkg::word_t data_in, data_out;
    logic [17:0] mem [int];
    int err_total, n_tests, cyc, seed, exp_loc, k;

    sync_flowthru_sram_port dut (.clk(clk), .rst_n(rst_n), .addr(addr), .read_not_write(read_not_write),
        .chip_sel_a_n(chip_sel_a_n), .chip_sel_mid(chip_sel_mid), .chip_sel_b_n(chip_sel_b_n),
        .advance_or_load_n(advance_or_load_n), .clock_gate_n(clock_gate_n), .lane_write_en_n(lane_write_en_n),
        .output_enable_n(output_enable_n), .sleep_request(sleep_request), .burst_mode_sel(burst_mode_sel),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .sleep_active(sleep_active));
    ctrl_model ctl (.clk(clk), .drive_en(wr_go), .word(wr_word), .dev_oe(data_oe), .dev_word(data_out),
        .lane_level(data_in));

    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; a run of this length needs well under 1000 cycles
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Expected burst offset and lane merge, written apart from the design helpers
    function automatic logic [1:0] offs(logic [1:0] s, logic [1:0] n, logic il);
        return il ? (s ^ n) : 2'(s + n);
    endfunction
    function automatic logic [17:0] merge(logic [17:0] o, logic [17:0] w, logic [1:0] we);
        return {we[1] ? w[17:9] : o[17:9], we[0] ? w[8:0] : o[8:0]};
    endfunction

    // Compare and count
    task automatic check(input logic [17:0] seen, input logic [17:0] want);
        n_tests++;
        if (seen !== want) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, want);
        end
    endtask

    task automatic final_report();
        if (err_total == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // One cycle: judge the data phase of the last live beat, then issue the next.
    // op codes: 0 none, 1 read, 2 write. A frozen edge leaves the model untouched.
    task automatic tick(input logic adv, input logic r, input logic [18:0] a, input logic [2:0] sel,
                        input logic [1:0] wn, input logic g);
        @(negedge clk);
        if (clock_gate_n) begin
            check(data_out, last_out);
            check({16'h0, data_oe}, {16'h0, last_oe});
        end else begin
            wr_go = (exp_op == 2'h2);
            if (exp_op == 2'h1) begin
                check({16'h0, data_oe}, output_enable_n ? 18'h0 : 18'h3);
                if (!output_enable_n) begin
                    check(data_out, mem[exp_loc]);
                end
            end else begin
                check({16'h0, data_oe}, 18'h0);
            end
            if (wr_go) begin
                wr_word = 18'($random(seed));
                mem[exp_loc] = merge(mem.exists(exp_loc) ? mem[exp_loc] : 18'h0, wr_word, exp_we);
            end
        end
        last_out = data_out;
        last_oe = data_oe;
        if (!g) begin
            if (!adv) begin
                op = (sel != 3'h7) ? 2'h0 : (r ? 2'h1 : 2'h2);
                base = a[18:2];
                start = a[1:0];
                bt = 2'h0;
            end else if (op != 2'h0) begin
                bt = bt + 2'h1;
            end
            exp_op = op;
            exp_loc = int'({base, offs(start, bt, burst_mode_sel)});
            exp_we = ~wn;
        end
        addr = a;
        read_not_write = r;
        chip_sel_a_n = ~sel[2];
        chip_sel_mid = sel[1];
        chip_sel_b_n = ~sel[0];
        advance_or_load_n = adv;
        lane_write_en_n = wn;
        clock_gate_n = g;
    endtask

    // Load then n advances; advances carry the opposite read/write and junk address
    task automatic burst(input logic r, input logic [18:0] a, input int n, input logic [1:0] wn);
        tick(1'b0, r, a, 3'h7, wn, 1'b0);
        repeat (n) begin
            tick(1'b1, ~r, 19'($random(seed)), 3'h7, r ? 2'($random(seed)) : wn, 1'b0);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) begin
            tick(1'b0, 1'b1, 19'h0, 3'h0, 2'h3, 1'b0);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        seed = 32'hbbb5;
        rst_n = 1'b0;
        {addr, read_not_write, lane_write_en_n} = '0;
        {chip_sel_mid, advance_or_load_n, clock_gate_n, output_enable_n, sleep_request} = 5'h0;
        {chip_sel_a_n, chip_sel_b_n, burst_mode_sel} = 3'h7;
        {op, exp_op, wr_go, wr_word} = '0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        idle(2);
        // Whole-word fill of the low 32 words and the top burst
        for (k = 0; k < 8; k++) begin
            burst(1'b0, 19'(k * 4 + k % 4), 3, 2'h0);
        end
        burst(1'b0, 19'h7fffe, 3, 2'h0);
        // Every start offset in both orders, run past the wrap
        for (k = 0; k < 8; k++) begin
            if (k % 4 == 0) begin
                burst_mode_sel = k[2];
                idle(3);
            end
            burst(1'b1, 19'((k % 4) * 5), 7, 2'h0);
        end
        burst(1'b1, 19'h7ffff, 7, 2'h0);
        // Each select alone stops a running burst; the advance after it is idle
        for (k = 0; k < 3; k++) begin
            burst(1'b1, 19'(k + 8), 1, 2'h0);
            tick(1'b0, 1'b1, 19'(k), ~(3'h1 << k), 2'h0, 1'b0);
            tick(1'b1, 1'b1, 19'h0, 3'h7, 2'h0, 1'b0);
        end
        // Single-lane write read back at once
        tick(1'b0, 1'b0, 19'h9, 3'h7, 2'h2, 1'b0);
        tick(1'b0, 1'b1, 19'h9, 3'h7, 2'h1, 1'b0);
        // Random mix of loads, advances, deselects and frozen edges
        repeat (400) begin
            k = $random(seed) & 7;
            tick(k < 3, 1'($random(seed)), {14'h0, 5'($random(seed))}, (k == 5) ? 3'($random(seed)) : 3'h7,
                 2'($random(seed)), k == 6);
        end
        // Reads with the output enable high leave the lanes released
        idle(1);
        output_enable_n = 1'b1;
        idle(3);
        burst(1'b1, 19'h4, 3, 2'h0);
        idle(1);
        output_enable_n = 1'b0;
        idle(3);
        // Sleep entry and exit take two edges each
        sleep_request = 1'b1;
        idle(3);
        check({17'h0, sleep_active}, 18'h1);
        sleep_request = 1'b0;
        idle(3);
        check({17'h0, sleep_active}, 18'h0);
        burst(1'b1, 19'h2, 3, 2'h0);
        idle(1);
        final_report();
    end
endmodule
